// ---- gtg_regs.svh ----
/*
 Register offsets, field positions, reset values and the rule summary of the
 gong tone generator. Assumes inclusion by bare name from the core and
 the testbench files.
*/
// Contract
// - Tone frequency is trigger over 2*(divider+1)
// - Trigger rate is module clock over prescaler+1
// - Nonzero amplitude write starts gong, sets flag
// - Zero amplitude write stops tone, clears flag
// - Restart during tone begins with low phase
// - Codes 0..5 give update rate tone/2^code
// - Codes 6 and 7 hold amplitude constant
// - Each update subtracts one thirty-second
// - Update loads 13-bit latch, top eight to compare
// - New PWM value shows from next high phase
// - Duty about amplitude+1 over prescaler+1, saturating
// - Top eight bits zero ends the gong
// - Read returns active flag in bit 7
// - Max constant bit forces full amplitude
// - Divider and duration change while active
// - Continuous tone ends only by write
`ifndef GTG_REGS_SVH
`define GTG_REGS_SVH
`define GTG_OFS_AMPL      4'h0
`define GTG_OFS_DIVIDER   4'h1
`define GTG_OFS_DECAY     4'h2
`define GTG_OFS_PRESCALER 4'h3
`define GTG_OFS_CLKSEL    4'h4
`define GTG_ACTIVE_BIT    7
`define GTG_DIV_MSB       6
`define GTG_DUR_MSB       2
`define GTG_MCA_BIT       7
`define GTG_RST_DIVIDER   7'h00
`define GTG_RST_DUR       3'h0
`define GTG_RST_PRESCALER 8'h01
`define GTG_RST_CLKSEL    5'h00
`define GTG_DUR_LAST      3'h5
`endif

// ---- gtg_pkg.sv ----
/*
 Types of the gong tone generator. Assumes gtg_regs.svh beside it.
*/
package gtg_pkg;
	// Gong sequencing
	typedef enum logic [0:0] {
		GTG_IDLE = 1'b0,
		GTG_RUN  = 1'b1
	} gtg_mode_t;
	// Register bus request
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} gtg_bus_t;
endpackage

// ---- gtg_clk_sel.sv ----
/*
 Module clock option: a free divider from the system clock giving one-cycle
 enable pulses at clk/2^n. Assumes one clock and async active high reset.
*/
module gtg_clk_sel #(
	parameter int STAGES = 17
) (
	input  wire logic       clk_in,
	input  wire logic       sys_rst_in,
	input  wire logic       run_in,
	input  wire logic [4:0] sel_in,
	output logic            tick_out
);
	// Refuse a divider depth that the five-bit select cannot address
	if (STAGES < 1 || STAGES > 31) begin : g_bad_stages
		$error("STAGES out of range");
	end
	// Free counter; bit n toggling sets rate clk/2^(n+1)
	logic [STAGES-1:0] cnt;
	logic [STAGES-1:0] next_cnt;
	always_comb begin
		next_cnt = run_in ? cnt + 1'b1 : '0;
	end
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			cnt <= '0;
		end else begin
			cnt <= next_cnt;
		end
	end
	// Select 0, or any select above STAGES, is the full rate; otherwise select n fires when the low n bits wrap
	always_comb begin
		if (!run_in) begin
			tick_out = 1'b0;
		end else if (sel_in == 5'h00 || 32'(sel_in) > STAGES) begin
			tick_out = 1'b1;
		end else begin
			tick_out = ((cnt & ((STAGES'(1) << sel_in) - 1'b1)) == '0);
		end
	end
endmodule

// ---- gtg_core.sv ----
/*
 Gong tone generator: register port, trigger prescaler, 8-bit PWM, tone
 divider, decay accumulator and gated output.
 The module clock option is a divider of the system clock that gives
 one-cycle enables, so the whole block lives in one clock domain.
 Assumes a single 125 MHz clock, async active high reset, and a master
 that keeps strobes one cycle wide and never raises both at once.
 Assumes the gong pin is already routed to its special output function
 before the first start, and that software programs the prescaler,
 divider and duration before starting; a zero prescaler is not guarded.
 The slave never stalls: writes land at the strobe edge, reads answer
 one cycle later and only then. Only the active flag can be read back;
 the current amplitude stays hidden by design.
*/
// Implementation choices: strobed register access and the placing of the registers.
`include "gtg_regs.svh"
module gtg_core #(
	parameter int CLK_STAGES = 17
) (
	input  wire logic       clk_in,
	input  wire logic       sys_rst_in,
	input  wire logic [3:0] addr_in,
	input  wire logic [7:0] wdata_in,
	input  wire logic       wr_in,
	input  wire logic       rd_in,
	output logic      [7:0] rdata_out,
	output logic            gong_out,
	output logic            active_out
);
	// Refuse a clock option divider the select field cannot address
	if (CLK_STAGES < 1 || CLK_STAGES > 31) begin : g_bad_stages
		$error("CLK_STAGES out of range");
	end

	// Whole state in one struct: one comb process fills next_st and one
	// flip-flop process registers it, so no field can get a second driver.
	// Configuration fields live here too, so a write and the tone logic
	// always see the same copy.
	typedef struct packed {
		gtg_pkg::gtg_mode_t mode;      // Running or idle
		logic [6:0]  divider;          // Tone divider
		logic [2:0]  dur;              // Duration factor
		logic        mca;              // Max constant amplitude
		logic [7:0]  prescaler;        // Trigger prescaler
		logic [4:0]  clksel;           // Module clock option
		logic [7:0]  pre_cnt;          // Prescaler / PWM counter
		logic [6:0]  tone_cnt;         // Tone half period counter
		logic        tone;             // Tone square wave
		logic [4:0]  dec_cnt;          // Full tone cycles since update
		logic [12:0] ampl;             // Amplitude latch
		logic [7:0]  cmp_run;          // Latest compare, shown from next high phase
		logic [7:0]  cmp_out;          // Compare visible at the output
		logic        pwm;              // PWM level
		logic [7:0]  rdata;            // Read data
		logic        gong;             // Output pin level
	} gtg_state_t;

	// Working signals around the state register
	gtg_state_t st;                    // Registered state
	gtg_state_t next_st;               // Next state
	gtg_pkg::gtg_bus_t bus;            // Bundled request
	logic       tick;                  // Module clock enable
	logic [12:0] sum;                  // Adder path result
	logic       trig;                  // Trigger pulse
	logic       upd;                   // Decrement pulse

	// Bundle the port request; the strobes are one cycle wide, so a
	// request is acted on exactly once
	assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

	// Module clock runs only while active; gating it by the active flag
	// also restarts the option divider from zero on every start from idle, which
	// keeps the first tone phase length repeatable
	gtg_clk_sel #(
		.STAGES(CLK_STAGES)
	) u_clk (
		.clk_in    (clk_in),
		.sys_rst_in(sys_rst_in),
		.run_in    (st.mode == gtg_pkg::GTG_RUN),
		.sel_in    (st.clksel),
		.tick_out  (tick)
	);

	// Adder subtracts one thirty-second of the latch
	// The latch keeps five fraction bits; while the top byte is nonzero the latch
	// still shrinks by at least one step per update, so under codes 0 to 5 the gong always ends
	assign sum = st.ampl - {5'h00, st.ampl[12:5]};
	// Trigger at module clock over prescaler+1
	// The PWM counter doubles as the prescaler, so one PWM period is
	// exactly one trigger interval
	assign trig = tick && (st.pre_cnt == st.prescaler);
	// Tone cycle ends on the falling half; update every 2^code cycles
	// Codes 6 and 7 fail the range test, which freezes the amplitude
	assign upd = trig && (st.tone_cnt == st.divider) && st.tone
		&& (st.dur <= `GTG_DUR_LAST)
		&& ((st.dec_cnt & ((5'h01 << st.dur) - 5'h01)) == ((5'h01 << st.dur) - 5'h01));

	// Next state: configuration, tone, PWM and decay in one place
	// Later assignments win, so a register write overrides the tone
	// logic of the same cycle, as the hand-over choices ask
	always_comb begin
		next_st = st;
		// Read data stand for one cycle only
		next_st.rdata = 8'h00;
		if (st.mode == gtg_pkg::GTG_RUN) begin
			// PWM counter over prescaler+1 ticks
			// Nothing moves between module clock enables
			if (tick) begin
				next_st.pre_cnt = trig ? 8'h00 : st.pre_cnt + 8'h01;
				// Duty (ampl+1)/(pre+1), saturating
				next_st.pwm = st.mca || (next_st.pre_cnt <= st.cmp_out);
			end
			// Tone toggles every divider+1 triggers
			// A compare of >= lets a smaller divider take effect at once
			if (trig) begin
				if (st.tone_cnt >= st.divider) begin
					next_st.tone_cnt = 7'h00;
					next_st.tone = ~st.tone;
					// Low-to-high: running value becomes visible
					if (!st.tone) begin
						next_st.cmp_out = st.cmp_run;
					end else begin
						// High-to-low ends a full tone cycle
						next_st.dec_cnt = st.dec_cnt + 5'h01;
					end
				end else begin
					next_st.tone_cnt = st.tone_cnt + 7'h01;
				end
			end
			// Latch adder, copy top byte to PWM
			if (upd) begin
				next_st.ampl = sum;
				next_st.cmp_run = sum[12:5];
				next_st.dec_cnt = 5'h00;
				// Top byte empty ends the gong
				// Write priority below lets a restart in this cycle win
				if (sum[12:5] == 8'h00) begin
					next_st.mode = gtg_pkg::GTG_IDLE;
				end
			end
		end
		// Writes; divider and duration apply at once
		// Offsets decode as an if chain; unknown offsets are ignored
		if (bus.wr) begin
			if (bus.addr == `GTG_OFS_AMPL) begin
				if (bus.wdata == 8'h00) begin
					// Stop at once
					next_st.mode = gtg_pkg::GTG_IDLE;
				end else begin
					// (Re)start low phase with new amplitude
					// The output compare loads at once: a fresh start has no
					// running phase that the old value would still need to finish
					next_st.mode = gtg_pkg::GTG_RUN;
					next_st.ampl = {bus.wdata, 5'h00};
					next_st.cmp_run = bus.wdata;
					next_st.cmp_out = bus.wdata;
					next_st.tone = 1'b0;
					next_st.tone_cnt = 7'h00;
					next_st.pre_cnt = 8'h00;
					next_st.dec_cnt = 5'h00;
					next_st.pwm = 1'b0;
				end
			end else if (bus.addr == `GTG_OFS_DIVIDER) begin
				next_st.divider = bus.wdata[`GTG_DIV_MSB:0];
			end else if (bus.addr == `GTG_OFS_DECAY) begin
				next_st.dur = bus.wdata[`GTG_DUR_MSB:0];
				next_st.mca = bus.wdata[`GTG_MCA_BIT];
			end else if (bus.addr == `GTG_OFS_PRESCALER) begin
				// Zero is the caller's fault; no guard here
				next_st.prescaler = bus.wdata;
			end else if (bus.addr == `GTG_OFS_CLKSEL) begin
				// Takes effect from the next cycle; the select feeds the option divider's enable directly
				next_st.clksel = bus.wdata[4:0];
			end
		end
		// Only the active flag is readable
		// Unmapped and write-only offsets read as zero
		if (bus.rd) begin
			if (bus.addr == `GTG_OFS_AMPL) begin
				next_st.rdata = {st.mode == gtg_pkg::GTG_RUN, 7'h00};
			end else begin
				next_st.rdata = 8'h00;
			end
		end
		// Tone gates PWM; low when inactive
		// Using next_st.mode makes a stop or self end silence the pin at once
		next_st.gong = (next_st.mode == gtg_pkg::GTG_RUN) && st.tone && st.pwm;
	end

	// State register; reset loads only constants
	// Configuration resets too, so a start straight after reset plays
	// with the default settings
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			st <= '{mode: gtg_pkg::GTG_IDLE, divider: `GTG_RST_DIVIDER,
				dur: `GTG_RST_DUR, mca: 1'b0, prescaler: `GTG_RST_PRESCALER,
				clksel: `GTG_RST_CLKSEL, default: '0};
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from flip-flops, so no glitch reaches the pin
	assign rdata_out  = st.rdata;
	assign gong_out   = st.gong;
	assign active_out = (st.mode == gtg_pkg::GTG_RUN);

	// Checks: each one guards a single rule and names it on its label line.
	// Writes of the same edge are excluded where a write legally overrides.
	// Start, stop and restart
	// A nonzero amplitude write raises the flag at the next edge
	a_start_sets_flag: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(wr_in && addr_in == `GTG_OFS_AMPL && wdata_in != 8'h00) |=> active_out)
		else $error("start did not set active");
	// The module clock enable stays off while idle
	a_idle_no_tick: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		!active_out |-> !tick)
		else $error("module clock runs while idle");
	// A zero write silences the pin and drops the flag at once
	a_stop_clears: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(wr_in && addr_in == `GTG_OFS_AMPL && wdata_in == 8'h00) |=> !active_out && !gong_out)
		else $error("stop did not clear");
	// A restart opens with a low tone phase, and the pin is low one cycle later
	a_restart_low: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(wr_in && addr_in == `GTG_OFS_AMPL && wdata_in != 8'h00) |=> !st.tone ##1 !gong_out)
		else $error("restart not in low phase");
	// The pin stays low whenever the module is idle
	a_idle_low: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		!active_out |-> !gong_out)
		else $error("output high while idle");
	// Tone, trigger and configuration
	// The tone flips once its half period count is used up
	a_tone_toggle: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(trig && st.tone_cnt >= st.divider && !wr_in) |=> st.tone != $past(st.tone))
		else $error("tone did not toggle");
	// Each trigger restarts the prescaler count
	a_pre_wrap: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(trig && !wr_in) |=> st.pre_cnt == 8'h00)
		else $error("prescaler did not wrap");
	// A divider write lands at the next edge
	a_div_write: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(wr_in && addr_in == `GTG_OFS_DIVIDER) |=> st.divider == $past(wdata_in[6:0]))
		else $error("divider write lost");
	// A duration write lands at the next edge
	a_dur_write: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(wr_in && addr_in == `GTG_OFS_DECAY) |=> st.dur == $past(wdata_in[2:0]))
		else $error("duration write lost");
	// Configuration writes never stop a running tone
	a_cfg_keeps_run: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(wr_in && addr_in != `GTG_OFS_AMPL && active_out && !upd) |=> active_out)
		else $error("config write stopped tone");
	// Decay
	// Codes 6 and 7 freeze the latch
	a_cont_holds: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(st.dur > `GTG_DUR_LAST && active_out && !wr_in) |=> $stable(st.ampl))
		else $error("continuous tone decayed");
	// A continuous tone never ends by itself
	a_cont_alive: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(st.dur > `GTG_DUR_LAST && active_out && !wr_in) |=> active_out)
		else $error("continuous tone ended");
	// Each update removes one thirty-second of the latch
	a_decay_step: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(upd && !wr_in) |=> st.ampl == $past(st.ampl) - {5'h00, $past(st.ampl[12:5])})
		else $error("bad decay step");
	// The top byte of the new latch feeds the running compare
	a_cmp_copy: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(upd && !wr_in) |=> st.cmp_run == st.ampl[12:5])
		else $error("compare not copied");
	// An empty top byte ends the gong
	a_end_zero: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(upd && sum[12:5] == 8'h00 && !wr_in) |=> !active_out)
		else $error("gong did not end");
	// PWM and read port
	// The running compare becomes visible as the tone goes high
	a_out_visible: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(trig && !st.tone && st.tone_cnt >= st.divider && !wr_in)
		|=> st.cmp_out == $past(st.cmp_run))
		else $error("compare not shown");
	// The visible compare never moves between tone toggles
	a_cmp_steady: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(!trig && !wr_in) |=> $stable(st.cmp_out))
		else $error("compare moved mid phase");
	// A compare at or above the prescaler saturates the duty
	a_pwm_full: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(tick && !wr_in && st.pre_cnt <= st.prescaler && st.cmp_out >= st.prescaler) |=> st.pwm)
		else $error("duty not saturated");
	// Max constant amplitude keeps the PWM high
	a_mca_full: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(tick && !wr_in && st.mca) |=> st.pwm)
		else $error("max amplitude not full");
	// A status read returns the flag in bit 7
	a_read_flag: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		(rd_in && addr_in == `GTG_OFS_AMPL) |=> rdata_out == {$past(active_out), 7'h00})
		else $error("bad status read");
	// Read data stand only in the cycle after the strobe
	a_rdata_one: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		!rd_in |=> rdata_out == 8'h00)
		else $error("read data outstayed");
	// Main scenarios
	c_start: cover property (@(posedge clk_in) $rose(active_out));
	c_restart: cover property (@(posedge clk_in) wr_in && addr_in == `GTG_OFS_AMPL && active_out);
	c_self_end: cover property (@(posedge clk_in) upd && sum[12:5] == 8'h00);
	c_tone_high: cover property (@(posedge clk_in) $rose(gong_out));
	c_mca: cover property (@(posedge clk_in) st.mca && gong_out);
endmodule

// ---- gtg_spk_model.sv ----
/*
 Speaker circuit model on the gong pin: measures the tone period and the
 longest high run. Assumes the pin is set up for its special output
 function and shares the design clock.
*/
module gtg_spk_model (
	input  wire logic clk_in,
	input  wire logic clr_in,
	input  wire logic gong_in,
	output int        period_out,
	output int        high_max_out
);
	timeunit 1ns;
	timeprecision 1ps;
	int   since_rise = 0; // Cycles since the last rising edge
	int   high_run   = 0; // Length of the current high run
	logic gong_q     = 0; // Previous pin level
	// Only listens: a speaker never loads the pin, so it cannot mask faults
	always @(posedge clk_in) begin
		gong_q <= gong_in;
		high_run <= gong_in ? high_run + 1 : 0;
		// Clear wins so a fresh window starts clean
		if (clr_in)
			high_max_out <= 0;
		else if (gong_in && high_run + 1 > high_max_out)
			high_max_out <= high_run + 1;
		// Period counts rising edge to rising edge
		if (gong_in && !gong_q) begin
			period_out <= since_rise;
			since_rise <= 1;
		end else
			since_rise <= since_rise + 1;
	end
endmodule

// ---- tb.sv ----
/*
 Testbench of the gong tone generator: register tasks and directed tests.
 Assumes gtg_core with clock option 0 outside the clock test, so there the module clock is the bus clock.
*/
`include "gtg_regs.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk_in = 0;   // Bus clock, 8 ns
	logic       sys_rst_in = 1;
	logic [3:0] addr_in = 0;
	logic [7:0] wdata_in = 0;
	logic       wr_in = 0;
	logic       rd_in = 0;
	logic       clr = 0;      // Restarts the speaker's high run window
	logic [7:0] rdata_out;
	logic       gong_out;
	logic       active_out;
	logic [7:0] rv;           // Read value
	int         period, high_max, n;
	int         err_count = 0;
	int         samples_checked = 0;
	int         cycles = 0;
	always #4 clk_in = ~clk_in;
	gtg_core u_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.gong_out(gong_out), .active_out(active_out));
	gtg_spk_model u_spk (.clk_in(clk_in), .clr_in(clr), .gong_in(gong_out),
		.period_out(period), .high_max_out(high_max));
	// Compare and count; four-state so an unknown never matches
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One-cycle write strobe
	task automatic wr(logic [3:0] a, logic [7:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1;
		@(posedge clk_in);
		wr_in <= 0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(logic [3:0] a, output logic [7:0] d);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1;
		@(posedge clk_in);
		rd_in <= 0;
		@(negedge clk_in);
		d = rdata_out;
	endtask
	// Fresh measuring window of the speaker, then let it run
	task automatic listen(int len);
		clr <= 1;
		@(posedge clk_in);
		clr <= 0;
		repeat (len) @(posedge clk_in);
	endtask
	// Cycles until the flag drops, bounded
	task automatic wait_idle(output int c);
		@(negedge clk_in);
		c = 0;
		while (active_out === 1'b1 && c < 2000) begin
			@(negedge clk_in);
			c++;
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Hang guard, well above the roughly 1600 cycles the tests need
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			print_verdict();
		end
	end
	initial begin
		repeat (2) @(posedge clk_in);
		sys_rst_in <= 0;
		@(negedge clk_in);
		check("active", active_out, 0);
		check("gong", gong_out, 0);
		rd(`GTG_OFS_AMPL, rv);
		check("status", rv, 8'h00);
		rd(4'hf, rv);
		check("unmapped", rv, 8'h00);
		$display("test reset done");
		// Setup before start; amplitude 1 reaches prescaler 1, so full duty
		wr(`GTG_OFS_PRESCALER, 8'h01);
		wr(`GTG_OFS_DIVIDER, 8'h03);
		wr(`GTG_OFS_DECAY, 8'h06);
		wr(`GTG_OFS_AMPL, 8'h01);
		@(negedge clk_in);
		check("start", active_out, 1);
		rd(`GTG_OFS_AMPL, rv);
		check("status", rv, 8'h80);
		listen(100);
		check("period", period, 16);
		check("high", high_max, 8);
		check("cont", active_out, 1);
		wr(`GTG_OFS_DIVIDER, 8'h01);
		repeat (60) @(posedge clk_in);
		check("newdiv", period, 8);
		check("still", active_out, 1);
		$display("test tone done");
		// Decaying code ends the continuous tone after one update
		wr(`GTG_OFS_DECAY, 8'h00);
		wait_idle(n);
		check("contend", n < 20, 1);
		listen(50);
		check("idle", high_max, 0);
		// Amplitude 1 needs one update: end after 2^code tone cycles of 16
		wr(`GTG_OFS_DIVIDER, 8'h03);
		for (int d = 0; d <= 5; d++) begin
			wr(`GTG_OFS_DECAY, d[7:0]);
			wr(`GTG_OFS_AMPL, 8'h01);
			wait_idle(n);
			check("decay", n >= 16 * (1 << d) - 3 && n <= 16 * (1 << d) + 4, 1);
		end
		$display("test decay done");
		// Duty 2 of 8 with prescaler 7, then forced full amplitude
		wr(`GTG_OFS_PRESCALER, 8'h07);
		wr(`GTG_OFS_DIVIDER, 8'h00);
		wr(`GTG_OFS_DECAY, 8'h06);
		wr(`GTG_OFS_AMPL, 8'h01);
		listen(40);
		check("duty", high_max, 2);
		wr(`GTG_OFS_DECAY, 8'h86);
		repeat (20) @(posedge clk_in);
		listen(40);
		check("mca", high_max, 8);
		// Restart while high must open with a low phase
		n = 0;
		while (gong_out !== 1'b1 && n < 50) begin
			@(negedge clk_in);
			n++;
		end
		wr(`GTG_OFS_AMPL, 8'h01);
		listen(4);
		check("restart", high_max, 0);
		wr(`GTG_OFS_AMPL, 8'h00);
		@(negedge clk_in);
		check("stop", active_out, 0);
		listen(20);
		check("silent", high_max, 0);
		$display("test mode done");
		// Option 1 halves the module clock, so the tone period doubles
		wr(`GTG_OFS_CLKSEL, 8'h01);
		wr(`GTG_OFS_PRESCALER, 8'h01);
		wr(`GTG_OFS_DIVIDER, 8'h03);
		wr(`GTG_OFS_DECAY, 8'h06);
		wr(`GTG_OFS_AMPL, 8'h01);
		listen(120);
		check("slowperiod", period, 32);
		check("slowhigh", high_max, 16);
		wr(`GTG_OFS_AMPL, 8'h00);
		$display("test clock done");
		print_verdict();
	end
endmodule
